// File: design/uabd_pkg.sv
// Package for the automatic bit-rate detector: constants and types.
// Assumes a single 50 MHz clock and synchronous active-high reset.
`default_nettype none
package uabd_pkg;
    // Calibration character the far end must send
    localparam logic [7:0] SYNC_CHAR = 8'h55;
    // Rising edges that end a measurement
    localparam logic [2:0] EDGE_LAST = 3'h5;
    // Divisor counter limits
    localparam logic [15:0] DIV_ZERO = 16'h0000;
    localparam logic [15:0] DIV_MAX = 16'hFFFF;
    // Detection counter clock dividers per mode pair
    localparam logic [9:0] DIV_SLOW = 10'h200;
    localparam logic [9:0] DIV_MID = 10'h080;
    localparam logic [9:0] DIV_FAST = 10'h020;
    // Normal bit-clock prescale: x16 and x4
    localparam logic [4:0] PRE_LOW = 5'h10;
    localparam logic [4:0] PRE_HIGH = 5'h04;
    // Status FIFO shape
    localparam int FIFO_W = 17;
    localparam int FIFO_D = 4;
    // Detector states
    typedef enum logic [1:0] {
        UABD_IDLE,
        UABD_BREAK,
        UABD_START,
        UABD_COUNT
    } uabd_state_type;
endpackage
`default_nettype wire

// File: design/uabd_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and synchronous active-high reset.
`default_nettype none
module uabd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    // Storage
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    // Honest full and empty
    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rd_r];
    // Write side
    always_ff @(posedge clock) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end
    // Pointers and fill count
    always_ff @(posedge clock) begin
        if (srst) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    a_fifo_no_overrun: assert property (@(posedge clock) disable iff (srst)
        cnt_r <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule
`default_nettype wire

// File: design/uabd_detect.sv
// Automatic bit-rate detector with divisor and bit-rate tick generator.
// Assumes serial_in_line asynchronous to clock; control bits are ports.
`default_nettype none
module uabd_detect (
    input wire logic clock,
    input wire logic srst,
    input wire logic serial_in_line, // Received line
    input wire logic sync_mode, // 1 = synchronous mode
    input wire logic wide_divisor_enable,
    input wire logic high_speed_select,
    input wire logic wake_on_break_enable,
    input wire logic rate_enable_set, // Pulse: software sets enable
    input wire logic rate_enable_clear, // Pulse: software clears enable
    input wire logic overflow_set, // Pulse: software sets flag
    input wire logic overflow_clear, // Pulse: software clears flag
    input wire logic div_write_low, // Pulse: write low divisor byte
    input wire logic div_write_high, // Pulse: write high divisor byte
    input wire logic [7:0] div_write_data,
    input wire logic receive_buffer_read, // Pulse: buffer read
    output logic auto_rate_enable,
    output logic auto_rate_detect_mode, // Measurement running
    output logic auto_rate_overflow_flag,
    output logic [7:0] divisor_low_byte,
    output logic [7:0] divisor_high_byte,
    output logic receive_done_flag,
    output logic [7:0] receive_buffer, // Discardable content
    output logic receiver_hold_idle, // Keeps receiver in idle
    output logic bit_tick, // One pulse per sampling clock
    output logic result_valid, // Status stream out
    input wire logic result_ready,
    output logic [16:0] result_data // {overflow, divisor}
);
    // Detection counter prescale from mode pair
    function automatic logic [9:0] sel_div(input logic w, input logic h);
        unique case ({w, h})
            2'b00: sel_div = uabd_pkg::DIV_SLOW;
            2'b11: sel_div = uabd_pkg::DIV_FAST;
            default: sel_div = uabd_pkg::DIV_MID;
        endcase
    endfunction

    // Synchroniser and edge detection
    logic rx_meta_r;
    logic rx_sync_r;
    logic rx_prev_r;
    // Control state
    uabd_pkg::uabd_state_type state_r;
    uabd_pkg::uabd_state_type state_nxt;
    logic enable_r;
    logic ovf_r;
    logic done_r;
    logic [15:0] div_r;
    logic [2:0] edges_r;
    logic [9:0] pre_r;
    logic [4:0] sub_r;
    logic [15:0] tick_cnt_r;
    logic busy_r;

    // Named decodes
    wire allowed = !sync_mode && !wake_on_break_enable;
    wire rx_fall = rx_prev_r && !rx_sync_r;
    wire rx_rise = !rx_prev_r && rx_sync_r;
    wire [9:0] pre_lim = sel_div(wide_divisor_enable, high_speed_select);
    wire pre_wrap = (pre_r == pre_lim - 10'h001);
    wire counting = (state_r == uabd_pkg::UABD_COUNT);
    wire div_step = counting && pre_wrap;
    wire div_roll = div_step && (div_r == uabd_pkg::DIV_MAX);
    wire fifth = counting && rx_rise
        && (edges_r == uabd_pkg::EDGE_LAST - 3'h1);
    wire en_rise = rate_enable_set && !enable_r;
    wire fifo_ready;
    wire [4:0] sub_lim = (high_speed_select || sync_mode)
        ? uabd_pkg::PRE_HIGH : uabd_pkg::PRE_LOW;
    wire sub_wrap = (sub_r == sub_lim - 5'h01);

    // Two-stage synchroniser; only stage two is observed
    always_ff @(posedge clock) begin
        if (srst) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
            rx_prev_r <= 1'b1;
        end else begin
            rx_meta_r <= serial_in_line;
            rx_sync_r <= rx_meta_r;
            rx_prev_r <= rx_sync_r;
        end
    end

    // Next state of the detector
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            uabd_pkg::UABD_IDLE: begin
                // Wake enabled with detection waits out the break
                if (en_rise && wake_on_break_enable && !sync_mode) begin
                    state_nxt = uabd_pkg::UABD_BREAK;
                end else if (en_rise && allowed) begin
                    state_nxt = uabd_pkg::UABD_START;
                end
            end
            uabd_pkg::UABD_BREAK: begin
                // Break ends on the line returning high
                if (rx_rise) begin
                    state_nxt = uabd_pkg::UABD_START;
                end
            end
            uabd_pkg::UABD_START: begin
                // Start bit falling edge arms counting
                if (rx_fall) begin
                    state_nxt = uabd_pkg::UABD_COUNT;
                end
            end
            uabd_pkg::UABD_COUNT: begin
                // Fifth rise ends; rollover does not
                if (fifth) begin
                    state_nxt = uabd_pkg::UABD_IDLE;
                end
            end
        endcase
        if (!enable_r && state_r != uabd_pkg::UABD_IDLE) begin
            state_nxt = uabd_pkg::UABD_IDLE;
        end
    end

    // Detector state and enable bit
    always_ff @(posedge clock) begin
        if (srst) begin
            state_r <= uabd_pkg::UABD_IDLE;
            enable_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (fifth) begin
                enable_r <= 1'b0;
            end else if (rate_enable_set) begin
                enable_r <= 1'b1;
            end else if (rate_enable_clear) begin
                enable_r <= 1'b0;
            end
        end
    end

    // Edge count and detection prescaler
    always_ff @(posedge clock) begin
        if (srst || !counting) begin
            edges_r <= '0;
            pre_r <= '0;
        end else begin
            if (rx_rise) begin
                edges_r <= edges_r + 3'h1;
            end
            // Time only from the first rise onward
            if (edges_r != 3'h0 || rx_rise) begin
                pre_r <= pre_wrap ? '0 : pre_r + 10'h001;
            end
        end
    end

    // Divisor register pair: cleared, counted, or written
    always_ff @(posedge clock) begin
        if (srst) begin
            div_r <= uabd_pkg::DIV_ZERO;
        end else if (en_rise && (allowed || wake_on_break_enable)) begin
            div_r <= uabd_pkg::DIV_ZERO;
        end else if (div_step && edges_r != 3'h0) begin
            // Both bytes step together as one counter
            div_r <= div_r + 16'h0001;
        end else if (!busy_r && div_write_low) begin
            div_r[7:0] <= div_write_data;
        end else if (!busy_r && div_write_high) begin
            div_r[15:8] <= div_write_data;
        end
    end

    // Overflow flag: hardware set beats software clear
    always_ff @(posedge clock) begin
        if (srst) begin
            ovf_r <= 1'b0;
        end else if ((div_roll && edges_r != 3'h0) || overflow_set) begin
            // Hardware wrap or software set
            ovf_r <= 1'b1;
        end else if (overflow_clear) begin
            ovf_r <= 1'b0;
        end
    end

    // Receive-complete flag: set wins over buffer read
    always_ff @(posedge clock) begin
        if (srst) begin
            done_r <= 1'b0;
        end else if (fifth) begin
            done_r <= 1'b1;
        end else if (receive_buffer_read) begin
            // Software read of the buffer drops it
            done_r <= 1'b0;
        end
    end

    // Busy while anything but idle
    always_ff @(posedge clock) begin
        if (srst) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= (state_nxt != uabd_pkg::UABD_IDLE);
        end
    end

    // Bit-rate tick generator in normal operation
    always_ff @(posedge clock) begin
        if (srst || busy_r) begin
            // Quiet while the generator serves as a counter
            sub_r <= '0;
            tick_cnt_r <= '0;
            bit_tick <= 1'b0;
        end else begin
            sub_r <= sub_wrap ? '0 : sub_r + 5'h01;
            bit_tick <= 1'b0;
            // Divisor compare once per prescaled sub-tick
            if (sub_wrap) begin
                if (tick_cnt_r == div_r) begin
                    tick_cnt_r <= '0;
                    bit_tick <= 1'b1;
                end else begin
                    tick_cnt_r <= tick_cnt_r + 16'h0001;
                end
            end
        end
    end

    // Result FIFO: one entry per finished measurement while it has room; a fifth edge with the FIFO full is dropped
    uabd_fifo #(
        .WIDTH(uabd_pkg::FIFO_W),
        .DEPTH(uabd_pkg::FIFO_D)
    ) u_fifo (
        .clock(clock),
        .srst(srst),
        .in_valid(fifth),
        .in_ready(fifo_ready),
        .in_data({ovf_r, div_r}),
        .out_valid(result_valid),
        .out_ready(result_ready),
        .out_data(result_data)
    );

    // Outputs
    assign auto_rate_enable = enable_r;
    assign auto_rate_detect_mode = busy_r;
    assign auto_rate_overflow_flag = ovf_r;
    assign divisor_low_byte = div_r[7:0];
    assign divisor_high_byte = div_r[15:8];
    assign receive_done_flag = done_r;
    assign receive_buffer = uabd_pkg::SYNC_CHAR;
    assign receiver_hold_idle = busy_r;

    // Checks

    // Hardware clears the enable bit at the closing edge
    a_fifth_clears_en: assert property (
        @(posedge clock) disable iff (srst)
        fifth |=> !enable_r)
        else $error("enable not cleared at fifth edge");

    // Closing edge raises the receive-complete flag
    a_fifth_sets_done: assert property (
        @(posedge clock) disable iff (srst)
        fifth |=> done_r)
        else $error("done flag not set");

    // Flag rises only from a closing edge
    a_done_needs_fifth: assert property (
        @(posedge clock) disable iff (srst)
        $rose(done_r) |-> $past(fifth))
        else $error("done flag set without fifth edge");

    // Rollover trapped; enable kept unless ended or cleared
    a_roll_sets_ovf: assert property (
        @(posedge clock) disable iff (srst)
        (div_roll && edges_r != 3'h0)
        |=> ovf_r && (enable_r || $past(fifth) || $past(rate_enable_clear)))
        else $error("rollover not trapped");

    // Rollover does not leave the counting state
    a_roll_keeps_mode: assert property (
        @(posedge clock) disable iff (srst)
        (div_roll && !fifth && enable_r) |=> counting)
        else $error("rollover ended detection");

    // Arming straight to start only in the permitted mode
    a_start_needs_ok: assert property (
        @(posedge clock) disable iff (srst)
        (state_r == uabd_pkg::UABD_IDLE
            && state_nxt == uabd_pkg::UABD_START) |-> allowed)
        else $error("detection armed in wrong mode");

    // Arming empties the divisor pair
    a_enable_clears_div: assert property (
        @(posedge clock) disable iff (srst)
        (en_rise && allowed) |=> div_r == uabd_pkg::DIV_ZERO)
        else $error("divisor not cleared");

    // Receiver stays idle in every counting cycle
    a_hold_rx_idle: assert property (
        @(posedge clock) disable iff (srst)
        counting |-> receiver_hold_idle)
        else $error("receiver not held idle");

    // One divisor step per prescaled tick
    a_count_rate: assert property (
        @(posedge clock) disable iff (srst)
        (div_step && edges_r != 3'h0 && !fifth)
        |=> div_r == $past(div_r) + 16'h0001)
        else $error("divisor did not step");

    // No sampling ticks while the generator times the line
    a_tick_quiet_busy: assert property (
        @(posedge clock) disable iff (srst)
        busy_r |=> !bit_tick)
        else $error("bit tick during detection");

    // Main scenarios
    c_full_measure: cover property (@(posedge clock) fifth);
    c_rollover: cover property (@(posedge clock) div_roll);
    c_after_break: cover property (@(posedge clock)
        state_r == uabd_pkg::UABD_BREAK ##1 state_r == uabd_pkg::UABD_START);
    c_fifo_full: cover property (@(posedge clock) fifth && !fifo_ready);
endmodule
`default_nettype wire

// File: dv/uabd_tx_model.sv
// Far-end serial transmitter model: sync characters and breaks.
// Assumes its tasks are called just after a rising clock edge.
`default_nettype none
module uabd_tx_model (
    input wire logic clock,
    output logic serial_in_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // Line idles high between frames
    initial serial_in_line = 1'b1;
    // Hold one line level for a number of clocks
    task automatic hold(input logic lvl, input int clks);
        serial_in_line = lvl;
        repeat (clks) @(posedge clock);
        #1;
    endtask
    // Start bit, eight data bits LSB first, stop bit
    task automatic send_sync(input int bclk);
        hold(1'b0, bclk);
        for (int i = 0; i < 8; i++) begin
            hold(uabd_pkg::SYNC_CHAR[i], bclk);
        end
        hold(1'b1, bclk);
    endtask
    // Break: long low, then a short idle before the next frame
    task automatic send_break(input int clks);
        hold(1'b0, clks);
        hold(1'b1, clks / 4);
    endtask
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the automatic bit-rate detector.
// Assumes a 50 MHz clock and the transmitter model on the line.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic sync_mode = 1'b0, wide_divisor_enable = 1'b0;
    logic high_speed_select = 1'b0, wake_on_break_enable = 1'b0;
    logic rate_enable_set = 1'b0, rate_enable_clear = 1'b0;
    logic overflow_set = 1'b0, overflow_clear = 1'b0;
    logic div_write_low = 1'b0, div_write_high = 1'b0;
    logic [7:0] div_write_data = 8'h00;
    logic receive_buffer_read = 1'b0, result_ready = 1'b0;
    wire logic serial_in_line;
    wire logic auto_rate_enable, auto_rate_detect_mode;
    wire logic auto_rate_overflow_flag, receive_done_flag;
    wire logic receiver_hold_idle, bit_tick, result_valid;
    wire logic [7:0] divisor_low_byte, divisor_high_byte, receive_buffer;
    wire logic [16:0] result_data;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    // Bit length per mode {wide, high}: two counter steps per bit
    int bclk_tab[4] = '{1024, 256, 256, 64};

    uabd_detect u_uabd_detect (.clock(clock), .srst(srst),
        .serial_in_line(serial_in_line), .sync_mode(sync_mode),
        .wide_divisor_enable(wide_divisor_enable),
        .high_speed_select(high_speed_select),
        .wake_on_break_enable(wake_on_break_enable),
        .rate_enable_set(rate_enable_set),
        .rate_enable_clear(rate_enable_clear),
        .overflow_set(overflow_set), .overflow_clear(overflow_clear),
        .div_write_low(div_write_low), .div_write_high(div_write_high),
        .div_write_data(div_write_data),
        .receive_buffer_read(receive_buffer_read),
        .auto_rate_enable(auto_rate_enable),
        .auto_rate_detect_mode(auto_rate_detect_mode),
        .auto_rate_overflow_flag(auto_rate_overflow_flag),
        .divisor_low_byte(divisor_low_byte),
        .divisor_high_byte(divisor_high_byte),
        .receive_done_flag(receive_done_flag),
        .receive_buffer(receive_buffer),
        .receiver_hold_idle(receiver_hold_idle), .bit_tick(bit_tick),
        .result_valid(result_valid), .result_ready(result_ready),
        .result_data(result_data));
    uabd_tx_model u_uabd_tx_model (.clock(clock),
        .serial_in_line(serial_in_line));

    // Free-running clock, 20 ns period
    initial begin
        forever #10 clock = ~clock;
    end
    // Hang guard, well above the expected run length
    always @(posedge clock) begin
        cyc++;
        if (cyc == 50000) begin
            fails++;
            end_sim();
        end
    end
    // One clock, then let that edge's updates land
    task automatic step();
        @(posedge clock);
        #1;
    endtask
    // Exact compare
    task automatic chk(input string what, input logic [23:0] exp,
        input logic [23:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Measured divisor: 8 bits of two steps each, one step of slack
    task automatic chk_rng(input string what, input logic [15:0] got);
        cmp_count++;
        if ((got >= 16'h000F) !== 1'b1 || (got <= 16'h0011) !== 1'b1) begin
            fails++;
            $display("CHECK FAILED %s expected 000F..0011 seen %h",
                what, got);
        end
    endtask
    // Bit tick gap for one {wide, high, sync} setting
    task automatic tick_gap(input logic [2:0] cfg, input int exp);
        int n;
        {wide_divisor_enable, high_speed_select, sync_mode} = cfg;
        n = 0;
        repeat (3) begin
            n = 0;
            do begin
                step();
                n++;
            end while (bit_tick !== 1'b1 && n < 300);
        end
        chk("tick gap", 24'(exp), 24'(n));
    endtask
    // Write divisor 3, then time the tick in three wide settings: x16, x4 and sync
    task automatic t_tick();
        div_write_data = 8'h03;
        div_write_low = 1'b1;
        step();
        div_write_low = 1'b0;
        div_write_data = 8'h00;
        div_write_high = 1'b1;
        step();
        div_write_high = 1'b0;
        tick_gap(3'b100, 64);
        tick_gap(3'b110, 16);
        tick_gap(3'b101, 16);
        sync_mode = 1'b0;
    endtask
    // Arm, optionally break first, send the sync character, judge
    task automatic run_detect(input logic [1:0] m, input int bclk,
        input logic brk);
        {wide_divisor_enable, high_speed_select} = m;
        // Nothing is transmitted until detection is armed
        rate_enable_set = 1'b1;
        step();
        rate_enable_set = 1'b0;
        chk("armed", 24'h010000, {auto_rate_enable, divisor_high_byte,
            divisor_low_byte});
        step();
        chk("busy", 24'h3, {auto_rate_detect_mode,
            receiver_hold_idle});
        if (brk) begin
            u_uabd_tx_model.send_break(13 * bclk);
        end
        u_uabd_tx_model.send_sync(bclk);
        chk_rng("divisor", {divisor_high_byte,
            divisor_low_byte});
        // Narrow modes: upper byte zero means no carry
        if (!m[1]) begin
            chk("no carry", 24'h0, 24'(divisor_high_byte));
        end
        chk("finished", 24'h1, {auto_rate_enable, auto_rate_detect_mode,
            receive_done_flag});
        chk("buffer", 24'h55, 24'(receive_buffer));
        receive_buffer_read = 1'b1;
        step();
        receive_buffer_read = 1'b0;
        chk("done clear", 24'h0, 24'(receive_done_flag));
    endtask
    // Drain the four kept results, the fifth was refused
    task automatic t_drain();
        for (int i = 0; i < 4; i++) begin
            chk("fifo valid", 24'h1, 24'(result_valid));
            chk("fifo flag", 24'h0, 24'(result_data[16]));
            chk_rng("fifo divisor", result_data[15:0]);
            result_ready = 1'b1;
            step();
            result_ready = 1'b0;
        end
        step();
        chk("fifo empty", 24'h0, 24'(result_valid));
    endtask
    // Software set and clear of the overflow flag, set wins
    task automatic t_ovf();
        overflow_set = 1'b1;
        step();
        overflow_clear = 1'b1;
        step();
        overflow_set = 1'b0;
        chk("ovf set", 24'h1, 24'(auto_rate_overflow_flag));
        step();
        overflow_clear = 1'b0;
        chk("ovf clear", 24'h0, 24'(auto_rate_overflow_flag));
    endtask
    // Sync mode arm, or an abort, must not measure
    task automatic t_none(input logic sy);
        sync_mode = sy;
        rate_enable_set = 1'b1;
        step();
        rate_enable_set = 1'b0;
        rate_enable_clear = !sy;
        step();
        rate_enable_clear = 1'b0;
        step();
        chk("idle", 24'h0, 24'(auto_rate_detect_mode));
        u_uabd_tx_model.send_sync(64);
        chk("no result", 24'h0, {auto_rate_detect_mode,
            receive_done_flag});
        rate_enable_clear = 1'b1;
        step();
        rate_enable_clear = 1'b0;
        sync_mode = 1'b0;
    endtask
    // Counts, then the verdict
    task automatic end_sim();
        $display("Compares %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge clock);
        #1;
        srst = 1'b0;
        chk("reset", 24'h0055, {auto_rate_enable, auto_rate_detect_mode,
            receive_done_flag, result_valid, receive_buffer});
        t_tick();
        for (int i = 0; i < 4; i++) begin
            run_detect(2'(i), bclk_tab[i], 1'b0);
        end
        wake_on_break_enable = 1'b1;
        run_detect(2'b11, 64, 1'b1);
        wake_on_break_enable = 1'b0;
        t_drain();
        t_ovf();
        t_none(1'b1);
        t_none(1'b0);
        end_sim();
    end
endmodule
`default_nettype wire
